// ===== rtl/crb_pkg.sv
// Constants, commands and carriers for the CPU RAM, bank and stack block.
// Assumes one 100 MHz clock shared by sequencer, ALU and APB master.
package crb_pkg;
    localparam int DIG_W    = 4;
    localparam int ADDR_W   = 10;
    localparam int PC_W     = 14;
    localparam int LCD_DIG  = 52;
    localparam int BANK_SZ  = 464;
    localparam int LEVELS   = 16;
    localparam int FRAME    = 4;
    localparam int MEM_DEP  = 1024 + 2 * BANK_SZ;
    localparam int SEG_W    = LCD_DIG * DIG_W;
    localparam logic [9:0] MR_BASE   = 10'h040;
    localparam logic [9:0] LCD_BASE  = 10'h050;
    localparam logic [9:0] LCD_LAST  = 10'h083;
    localparam logic [9:0] BANK_LO   = 10'h090;
    localparam logic [9:0] BANK_HI   = 10'h25F;
    localparam logic [9:0] BANK_REG  = 10'h03F;
    localparam logic [9:0] SP_STEP   = 10'h004;
    localparam logic [3:0] SP_FIXED  = 4'hF;
    localparam logic [5:0] SP_LOW_RST = 6'h3F;
    localparam logic [10:0] MEM_B1   = 11'h400;
    localparam logic [10:0] MEM_B2   = 11'h5D0;
    localparam logic [1:0] BANK_RST  = 2'h0;
    localparam logic [1:0] BANK_ONE  = 2'h1;
    localparam logic [1:0] BANK_TWO  = 2'h2;
    localparam logic [7:0] IDX_BANK  = 8'h3F;
    localparam logic [7:0] IDX_STAT  = 8'h40;
    localparam int STAT_SP_LSB = 0;
    localparam int STAT_CA_BIT = 16;
    localparam int STAT_ACC_LSB = 20;

    typedef enum logic [4:0] {
        OP_NOP, OP_RAM_RD, OP_RAM_WR, OP_IND_RD, OP_IND_WR,
        OP_MR_LOAD, OP_MR_XCHG, OP_CALL, OP_INT_ENTRY, OP_RTN,
        OP_INTERRUPT_RETURN_OP, OP_SEC, OP_REC, OP_ROTATE_LEFT_CARRY_OP, OP_ROTATE_RIGHT_CARRY_OP, OP_ALU,
        OP_LD_A, OP_LD_B, OP_LD_W, OP_LD_X, OP_LD_Y,
        OP_SWAP_X, OP_SWAP_Y, OP_SAVE_XY
    } crb_op_t;

    typedef struct packed {
        crb_op_t           op;
        logic [9:0]        addr;
        logic [3:0]        data;
        logic [PC_W-1:0]   pc;
        logic              status;
        logic              aluCarry;
    } crb_req_t;

    typedef struct packed {
        logic [3:0]        rdData;
        logic              retValid;
        logic              retFlags;
        logic [PC_W-1:0]   retPc;
        logic              retStatus;
        logic              retCarry;
    } crb_rsp_t;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] b;
        logic [1:0] w;
        logic [3:0] x;
        logic [3:0] y;
        logic [3:0] auxCol;
        logic [3:0] auxRow;
        logic       carry;
    } crb_regs_t;
endpackage

// ===== rtl/crb_ram_bank_stack.sv
// RAM areas, bank select, call stack and CPU working registers.
// Assumes the sequencer issues one command per cycle on clk; APB is same clock.
// What this block does
// - Sixteen memory registers, load and exchange with A
// - 52 LCD digits drive segment outputs continuously
// - Bit one lights segment, zero extinguishes it
// - 464 banked digits, three banks, register picks
// - Upper data area shared regardless of bank
// - Bank values zero, one, two select banks
// - Bank value three selects nothing, undefined; this design falls back to bank zero
// - Sixteen stack levels, four digits each
// - Call and interrupt push PC, status, carry
// - Plain return restores PC; interrupt return all
// - Unused stack digits are ordinary RAM
// - Four-bit A and B take results, transfers
// - W, X, Y form indirect RAM address
// - Y also gives D port bit index
// - Two auxiliary pointers save or swap X, Y
// - Carry follows ALU overflow after arithmetic
// - Set, clear and rotate instructions change carry
// - Carry saved on interrupt, reloaded on interrupt return only
// - Stack pointer resets top, steps by four
// - Top four stack pointer bits fixed ones
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module crb_ram_bank_stack
    import crb_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire crb_req_t        req,
    output crb_rsp_t             rsp,
    output crb_regs_t            regs,
    output logic [3:0]           dPortBit,
    output logic [SEG_W-1:0]     lcdSeg,
    output logic [9:0]           sp,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr
);
    logic [1:0]       rstPipe;
    logic             rstSync;
    logic [3:0]       mem [MEM_DEP];
    logic [1:0]       bankSel;
    logic [5:0]       spLow;
    logic [9:0]       spNow;
    logic [9:0]       popTop;
    logic [9:0]       indAddr;
    logic [9:0]       accAddr;
    logic [3:0]       rdDigit;
    logic [3:0]       mrValue;
    logic [9:0]       lcdOff;
    logic             wrOp;
    logic             apbAcc;
    logic             apbBankWr;

    // Strip reset through two flops so release is glitch-free on clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    function automatic logic inLcd(input logic [9:0] a);
        inLcd = (a >= LCD_BASE) && (a <= LCD_LAST);
    endfunction

    function automatic logic inBank(input logic [9:0] a);
        inBank = (a >= BANK_LO) && (a <= BANK_HI);
    endfunction

    // Banks one and two live above the flat 1K map; value three falls back to bank zero
    function automatic logic [10:0] physIdx(input logic [9:0] a, input logic [1:0] bk);
        logic [10:0] off;
        off = {1'b0, a - BANK_LO};
        if (inBank(a) && bk == BANK_ONE) begin
            physIdx = MEM_B1 + off;
        end else if (inBank(a) && bk == BANK_TWO) begin
            physIdx = MEM_B2 + off;
        end else begin
            physIdx = {1'b0, a};
        end
    endfunction

    assign spNow   = {SP_FIXED, spLow};
    // Pop address wraps inside the fixed top so an empty-stack return stays in the stack area
    assign popTop  = {SP_FIXED, spLow + SP_STEP[5:0]};
    assign indAddr = {regs.w, regs.x, regs.y};
    assign accAddr = (req.op == OP_IND_RD || req.op == OP_IND_WR) ? indAddr : req.addr;
    assign lcdOff  = accAddr - LCD_BASE;
    assign mrValue = mem[{1'b0, MR_BASE + {6'h00, req.addr[3:0]}}];
    assign wrOp    = (req.op == OP_RAM_WR) || (req.op == OP_IND_WR);

    always_comb begin
        if (inLcd(accAddr)) begin
            rdDigit = lcdSeg[{lcdOff[5:0], 2'b00} +: DIG_W];
        end else if (accAddr == BANK_REG) begin
            rdDigit = {2'b00, bankSel};
        end else begin
            rdDigit = mem[physIdx(accAddr, bankSel)];
        end
    end

    // Memory array: plain RAM, stack frames and memory registers share it
    always_ff @(posedge clk) begin
        if (wrOp && !inLcd(accAddr) && accAddr != BANK_REG) begin
            mem[physIdx(accAddr, bankSel)] <= req.data;
        end
        if (req.op == OP_MR_XCHG) begin
            mem[{1'b0, MR_BASE + {6'h00, req.addr[3:0]}}] <= regs.acc;
        end
        if (req.op == OP_CALL || req.op == OP_INT_ENTRY) begin
            mem[{1'b0, spNow}]          <= {req.status, regs.carry, req.pc[13:12]};
            mem[{1'b0, spNow - 10'h001}] <= req.pc[11:8];
            mem[{1'b0, spNow - 10'h002}] <= req.pc[7:4];
            mem[{1'b0, spNow - 10'h003}] <= req.pc[3:0];
        end
    end

    // Display digits are kept in flops so the segments need no read port
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            lcdSeg <= '0;
        end else if (wrOp && inLcd(accAddr)) begin
            lcdSeg[{lcdOff[5:0], 2'b00} +: DIG_W] <= req.data;
        end
    end

    assign apbAcc    = psel && penable && !pready;
    assign apbBankWr = apbAcc && pwrite && paddr[11:2] == {2'b00, IDX_BANK};

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            bankSel <= BANK_RST;
        end else if (apbBankWr) begin
            bankSel <= pwdata[1:0];
        end else if (wrOp && accAddr == BANK_REG) begin
            bankSel <= req.data[1:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            spLow <= SP_LOW_RST;
        end else if (req.op == OP_CALL || req.op == OP_INT_ENTRY) begin
            spLow <= spNow[5:0] - SP_STEP[5:0];
        end else if (req.op == OP_RTN || req.op == OP_INTERRUPT_RETURN_OP) begin
            spLow <= popTop[5:0];
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            sp <= {SP_FIXED, SP_LOW_RST};
        end else if (req.op == OP_CALL || req.op == OP_INT_ENTRY) begin
            sp <= {SP_FIXED, spNow[5:0] - SP_STEP[5:0]};
        end else if (req.op == OP_RTN || req.op == OP_INTERRUPT_RETURN_OP) begin
            sp <= popTop;
        end
    end

    // Accumulator, B and carry
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            regs.acc   <= '0;
            regs.b     <= '0;
            regs.carry <= 1'b0;
        end else begin
            case (req.op)
                OP_MR_LOAD, OP_MR_XCHG: regs.acc <= mrValue;
                OP_LD_A:  regs.acc <= req.data;
                OP_LD_B:  regs.b   <= req.data;
                OP_ALU: begin
                    regs.acc   <= req.data;
                    regs.carry <= req.aluCarry;
                end
                OP_SEC:   regs.carry <= 1'b1;
                OP_REC:   regs.carry <= 1'b0;
                OP_ROTATE_LEFT_CARRY_OP: begin
                    regs.acc   <= {regs.acc[2:0], regs.carry};
                    regs.carry <= regs.acc[3];
                end
                OP_ROTATE_RIGHT_CARRY_OP: begin
                    regs.acc   <= {regs.carry, regs.acc[3:1]};
                    regs.carry <= regs.acc[0];
                end
                OP_INTERRUPT_RETURN_OP:  regs.carry <= mem[{1'b0, popTop}][2];
                default: begin
                end
            endcase
        end
    end

    // Pointer registers
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            regs.w      <= '0;
            regs.x      <= '0;
            regs.y      <= '0;
            regs.auxCol <= '0;
            regs.auxRow <= '0;
        end else begin
            case (req.op)
                OP_LD_W: regs.w <= req.data[1:0];
                OP_LD_X: regs.x <= req.data;
                OP_LD_Y: regs.y <= req.data;
                OP_SWAP_X: begin
                    regs.x      <= regs.auxCol;
                    regs.auxCol <= regs.x;
                end
                OP_SWAP_Y: begin
                    regs.y      <= regs.auxRow;
                    regs.auxRow <= regs.y;
                end
                OP_SAVE_XY: begin
                    regs.auxCol <= regs.x;
                    regs.auxRow <= regs.y;
                end
                default: begin
                end
            endcase
        end
    end

    // D port bit loads on the same edge as Y, from its own flop
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            dPortBit <= '0;
        end else if (req.op == OP_LD_Y) begin
            dPortBit <= req.data;
        end else if (req.op == OP_SWAP_Y) begin
            dPortBit <= regs.auxRow;
        end
    end

    // Answers to the sequencer
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            rsp <= '0;
        end else begin
            rsp.retValid <= (req.op == OP_RTN) || (req.op == OP_INTERRUPT_RETURN_OP);
            rsp.retFlags <= (req.op == OP_INTERRUPT_RETURN_OP);
            if (req.op == OP_RAM_RD || req.op == OP_IND_RD) begin
                rsp.rdData <= rdDigit;
            end
            if (req.op == OP_RTN || req.op == OP_INTERRUPT_RETURN_OP) begin
                rsp.retPc <= {mem[{1'b0, popTop}][1:0], mem[{1'b0, popTop - 10'h001}],
                              mem[{1'b0, popTop - 10'h002}], mem[{1'b0, popTop - 10'h003}]};
                rsp.retStatus <= mem[{1'b0, popTop}][3];
                rsp.retCarry  <= mem[{1'b0, popTop}][2];
            end
        end
    end

    // APB slave: one wait state, every access finishes on the second access cycle
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apbAcc;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (apbAcc) begin
                if (paddr[11:2] == {2'b00, IDX_BANK}) begin
                    prdata[1:0] <= bankSel;
                end else if (paddr[11:2] == {2'b00, IDX_STAT} && !pwrite) begin
                    prdata[STAT_SP_LSB +: 10]  <= spNow;
                    prdata[STAT_CA_BIT]        <= regs.carry;
                    prdata[STAT_ACC_LSB +: 4]  <= regs.acc;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync);

    property p_mr_xchg;
        logic [3:0] v;
        (req.op == OP_MR_XCHG, v = mrValue) |=> regs.acc == v;
    endproperty
    a_mr_xchg: assert property (p_mr_xchg) else $error("MR exchange lost");

    property p_lcd_wr;
        (wrOp && inLcd(accAddr)) |=> lcdSeg[{$past(lcdOff[5:0]), 2'b00} +: 4] == $past(req.data);
    endproperty
    a_lcd_wr: assert property (p_lcd_wr) else $error("LCD digit not stored");

    property p_bank_map;
        wrOp && inBank(accAddr) && bankSel == BANK_TWO
            |=> mem[MEM_B2 + ($past(accAddr) - BANK_LO)] == $past(req.data);
    endproperty
    a_bank_map: assert property (p_bank_map) else $error("Bank two misplaced");

    property p_sp_call;
        (req.op == OP_CALL || req.op == OP_INT_ENTRY)
            |=> sp[5:0] == $past(spNow[5:0]) - SP_STEP[5:0];
    endproperty
    a_sp_call: assert property (p_sp_call) else $error("SP not lowered by four");

    property p_sp_fixed;
        spNow[9:6] == SP_FIXED && sp == spNow;
    endproperty
    a_sp_fixed: assert property (p_sp_fixed) else $error("SP top bits wrong");

    property p_alu_carry;
        req.op == OP_ALU |=> regs.carry == $past(req.aluCarry);
    endproperty
    a_alu_carry: assert property (p_alu_carry) else $error("Carry not from ALU");

    property p_sec;
        req.op == OP_SEC ##1 req.op == OP_REC |-> regs.carry ##1 !regs.carry;
    endproperty
    a_sec: assert property (p_sec) else $error("Set or clear carry failed");

    property p_rtn;
        req.op == OP_RTN |=> rsp.retValid && !rsp.retFlags && sp == $past(popTop);
    endproperty
    a_rtn: assert property (p_rtn) else $error("Plain return wrong");

    property p_int_carry;
        req.op == OP_INT_ENTRY ##1 req.op == OP_INTERRUPT_RETURN_OP |=> regs.carry == $past(regs.carry, 2);
    endproperty
    a_int_carry: assert property (p_int_carry) else $error("Carry not restored");

    property p_push_pc;
        req.op == OP_CALL ##1 req.op == OP_RTN |=> rsp.retPc == $past(req.pc, 2);
    endproperty
    a_push_pc: assert property (p_push_pc) else $error("Return PC mismatch");

    property p_apb;
        apbAcc |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB answer timing");

    c_call_ret: cover property (req.op == OP_CALL ##[1:20] req.op == OP_RTN);
    c_lcd: cover property (wrOp && inLcd(accAddr));
    c_bank1: cover property (wrOp && inBank(accAddr) && bankSel == BANK_ONE);
    c_apb_rd: cover property (pready && !pwrite && !pslverr);
endmodule

// ===== verification/crb_ram_bank_stack_tb.sv
// Self-checking bench for the RAM, bank, stack and working register block.
// Assumes the sequencer port and APB share clk; no partner model is needed.
`timescale 1ns/1ps
module crb_ram_bank_stack_tb;
    import crb_pkg::*;
    logic            clk;
    logic            rst_n;
    crb_req_t        req;
    crb_rsp_t        rsp;
    crb_regs_t       regs;
    logic [3:0]      dPortBit;
    logic [SEG_W-1:0] lcdSeg;
    logic [9:0]      sp;
    logic            psel, penable, pwrite, pready, pslverr;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            err;
    logic [13:0]     pcV;
    logic            stV, acV, mCa;
    logic [3:0]      mAcc, d, xs, ys;
    int              num_errors, total_checks, n, k;

    crb_ram_bank_stack dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .regs(regs),
        .dPortBit(dPortBit), .lcdSeg(lcdSeg), .sp(sp), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chkV(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkB(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One command, taken at the next edge; outputs looked at half a cycle later
    task automatic op(input crb_op_t o, input logic [9:0] a, input logic [3:0] dd);
        @(posedge clk);
        req <= '{op: o, addr: a, data: dd, pc: pcV, status: stV, aluCarry: acV};
        @(posedge clk);
        req.op <= OP_NOP;
        @(negedge clk);
    endtask

    task automatic rdDig(input logic [9:0] a, input logic [3:0] exp);
        op(OP_RAM_RD, a, 4'h0);
        chkV({28'h0, rsp.rdData}, {28'h0, exp});
    endtask

    // Two commands on consecutive edges, outputs looked at after the second
    task automatic op2(input crb_op_t o1, input crb_op_t o2);
        @(posedge clk);
        req <= '{op: o1, addr: 10'h0, data: 4'h0, pc: pcV, status: stV, aluCarry: acV};
        @(posedge clk);
        req.op <= o2;
        @(posedge clk);
        req.op <= OP_NOP;
        @(negedge clk);
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    function automatic logic [4:0] rot(input logic l, input logic c, input logic [3:0] a);
        return l ? {a, c} : {a[0], c, a[3:1]};
    endfunction

    initial begin
        rst_n = 1'b0;
        req = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pcV, stV, acV} = '0;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(2));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chkV({22'h0, sp}, 32'h0000_03FF);
        chkV({5'h0, regs}, 32'h0000_0000);
        chkV({24'h0, lcdSeg[7:0]}, 32'h0000_0000);
        apb(1'b0, {IDX_BANK, 2'b00}, 32'h0);
        chkV(rd, 32'h0000_0000);
        apb(1'b1, 12'h200, 32'h0000_0001);
        chkB(err, 1'b1);
        apb(1'b1, {IDX_STAT, 2'b00}, 32'h0000_0001);
        chkB(err, 1'b1);
        // Three banks hold distinct data at both ends of the banked range
        for (k = 0; k < 3; k++) begin
            apb(1'b1, {IDX_BANK, 2'b00}, 32'hFFFF_FFF0 | k);
            chkB(err, 1'b0);
            apb(1'b0, {IDX_BANK, 2'b00}, 32'h0);
            chkV(rd, k);
            op(OP_RAM_WR, BANK_LO, 4'(k + 5));
            op(OP_RAM_WR, BANK_HI, 4'(k + 9));
        end
        for (k = 0; k < 3; k++) begin
            apb(1'b1, {IDX_BANK, 2'b00}, k);
            rdDig(BANK_LO, 4'(k + 5));
            rdDig(BANK_HI, 4'(k + 9));
        end
        // Value three selects nothing; this design falls back to bank zero
        apb(1'b1, {IDX_BANK, 2'b00}, 32'h0000_0003);
        rdDig(BANK_REG, 4'h3);
        rdDig(BANK_LO, 4'h5);
        op(OP_RAM_WR, BANK_REG, 4'h1);
        apb(1'b0, {IDX_BANK, 2'b00}, 32'h0);
        chkV(rd, 32'h0000_0001);
        d = 4'($urandom);
        op(OP_RAM_WR, 10'h260, d);
        apb(1'b1, {IDX_BANK, 2'b00}, 32'h0);
        rdDig(10'h260, d);
        // LCD digits map onto segment outputs, both ends included
        for (k = 0; k < 6; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? LCD_DIG - 1 : int'($urandom % LCD_DIG);
            d = (k < 2) ? 4'hA : 4'($urandom);
            op(OP_RAM_WR, LCD_BASE + 10'(n), d);
            chkV({28'h0, lcdSeg[4*n +: 4]}, {28'h0, d});
        end
        // Memory registers: load and exchange with the accumulator
        for (k = 0; k < 16; k++) begin
            d = 4'($urandom);
            op(OP_RAM_WR, MR_BASE + 10'(k), d);
            op(OP_MR_LOAD, 10'(k), 4'h0);
            chkV({28'h0, regs.acc}, {28'h0, d});
            op(OP_LD_A, 10'h0, ~d);
            op(OP_MR_XCHG, 10'(k), 4'h0);
            chkV({28'h0, regs.acc}, {28'h0, d});
            op(OP_MR_LOAD, 10'(k), 4'h0);
            chkV({28'h0, regs.acc}, {28'h0, ~d});
        end
        // Carry: ALU overflow, set, clear, rotations through carry
        mAcc = ~d;
        op(OP_REC, 10'h0, 4'h0);
        mCa = 1'b0;
        for (k = 0; k < 40; k++) begin
            d = 4'($urandom);
            acV = 1'($urandom);
            case (k % 5)
                0: begin op(OP_ALU, 10'h0, d); {mCa, mAcc} = {acV, d}; end
                1: begin op(OP_SEC, 10'h0, d); mCa = 1'b1; end
                2: begin op(OP_REC, 10'h0, d); mCa = 1'b0; end
                3: begin op(OP_ROTATE_LEFT_CARRY_OP, 10'h0, d); {mCa, mAcc} = rot(1'b1, mCa, mAcc); end
                default: begin op(OP_ROTATE_RIGHT_CARRY_OP, 10'h0, d); {mCa, mAcc} = rot(1'b0, mCa, mAcc); end
            endcase
            chkB(regs.carry, mCa);
            chkV({28'h0, regs.acc}, {28'h0, mAcc});
        end
        // Nested calls, frame layout, plain and interrupt returns
        op(OP_SEC, 10'h0, 4'h0);
        pcV = 14'($urandom);
        stV = 1'b1;
        op(OP_CALL, 10'h0, 4'h0);
        chkV({22'h0, sp}, 32'h0000_03FB);
        rdDig(10'h3FF, {stV, 1'b1, pcV[13:12]});
        rdDig(10'h3FE, pcV[11:8]);
        rdDig(10'h3FD, pcV[7:4]);
        rdDig(10'h3FC, pcV[3:0]);
        pcV = ~pcV;
        stV = 1'b0;
        op(OP_INT_ENTRY, 10'h0, 4'h0);
        chkV({22'h0, sp}, 32'h0000_03F7);
        op(OP_REC, 10'h0, 4'h0);
        op(OP_INTERRUPT_RETURN_OP, 10'h0, 4'h0);
        chkB(rsp.retValid, 1'b1);
        chkB(rsp.retFlags, 1'b1);
        chkV({18'h0, rsp.retPc}, {18'h0, pcV});
        chkB(rsp.retStatus, 1'b0);
        chkB(regs.carry, 1'b1);
        op(OP_REC, 10'h0, 4'h0);
        op(OP_RTN, 10'h0, 4'h0);
        chkB(rsp.retFlags, 1'b0);
        chkV({18'h0, rsp.retPc}, {18'h0, ~pcV});
        chkB(regs.carry, 1'b0);
        chkV({22'h0, sp}, 32'h0000_03FF);
        @(negedge clk);
        chkB(rsp.retValid, 1'b0);
        op(OP_RAM_WR, 10'h3C0, 4'h6);
        rdDig(10'h3C0, 4'h6);
        // Back-to-back pairs: push then pop, set then clear
        pcV = 14'($urandom);
        stV = 1'b1;
        op2(OP_CALL, OP_RTN);
        chkV({18'h0, rsp.retPc}, {18'h0, pcV});
        chkV({22'h0, sp}, 32'h0000_03FF);
        op2(OP_SEC, OP_REC);
        chkB(regs.carry, 1'b0);
        op(OP_SEC, 10'h0, 4'h0);
        op2(OP_INT_ENTRY, OP_INTERRUPT_RETURN_OP);
        chkB(regs.carry, 1'b1);
        chkB(rsp.retStatus, stV);
        op(OP_REC, 10'h0, 4'h0);
        // Indirect addressing, port bit index, auxiliary pointers
        for (k = 0; k < 6; k++) begin
            xs = 4'($urandom % 12);
            ys = 4'($urandom);
            d = 4'($urandom);
            op(OP_LD_W, 10'h0, 4'h3);
            op(OP_LD_X, 10'h0, xs);
            op(OP_LD_Y, 10'h0, ys);
            chkV({28'h0, dPortBit}, {28'h0, ys});
            op(OP_IND_WR, 10'h0, d);
            rdDig({2'b11, xs, ys}, d);
            op(OP_IND_RD, 10'h0, 4'h0);
            chkV({28'h0, rsp.rdData}, {28'h0, d});
            op(OP_SAVE_XY, 10'h0, 4'h0);
            op(OP_LD_X, 10'h0, ~xs);
            op(OP_SWAP_X, 10'h0, 4'h0);
            op(OP_LD_Y, 10'h0, ~ys);
            op(OP_SWAP_Y, 10'h0, 4'h0);
            chkV({24'h0, regs.x, regs.y}, {24'h0, xs, ys});
            chkV({24'h0, regs.auxCol, regs.auxRow}, {24'h0, ~xs, ~ys});
            chkV({28'h0, dPortBit}, {28'h0, ys});
        end
        op(OP_LD_B, 10'h0, 4'h9);
        chkV({28'h0, regs.b}, 32'h0000_0009);
        apb(1'b0, {IDX_STAT, 2'b00}, 32'h0);
        chkV(rd, {8'h0, mAcc, 3'h0, 1'b0, 6'h0, 10'h3FF});
        summarize();
    end

    initial begin
        #900000;
        num_errors++;
        summarize();
    end
endmodule
